/* rtl/dbi_map.vh */
`ifndef DBI_MAP_VH
`define DBI_MAP_VH

// Machine state word positions seen by the invalidate engine
`define DBI_MSTATE_USER_BIT 14
`define DBI_MSTATE_XLATE_BIT 4

// Storage attribute layout (write-through, inhibited, coherent)
`define DBI_ATTR_W_BIT 2
`define DBI_ATTR_I_BIT 1
`define DBI_ATTR_M_BIT 0

// Cache geometry
`define DBI_ADDR_W 32
`define DBI_BLK_OFS_W 5

// Engine state width
`define DBI_ST_W 3

`endif

/* rtl/dbi_ea_gen.v */
`include "dbi_map.vh"

// Effective address from base and index registers
module dbi_ea_gen (
   input wire base_is_r0,
   input wire [`DBI_ADDR_W-1:0] base_gpr,
   input wire [`DBI_ADDR_W-1:0] index_gpr,
   output wire [`DBI_ADDR_W-1:0] ea
);

   wire [`DBI_ADDR_W-1:0] base_val;

   // Register zero in the base field reads as the value zero
   assign base_val = base_is_r0 ? {`DBI_ADDR_W{1'b0}} : base_gpr;
   assign ea = base_val + index_gpr;

endmodule

/* rtl/dbi_ctrl.v */
`include "dbi_map.vh"

// Behaviour
// - Invalidate accepted for cache work only in supervisor state.
// - Effective address is base plus index; base field zero means value zero.
// - Whole cache block holding the addressed byte is invalidated.
// - Direct-store segment makes the operation a no-op.
// - Coherent page: invalidate locally and in all other caches, no writeback.
// - Coherent page, locally absent: other copies still invalidated and discarded.
// - Non-coherent page: local invalidate only, no broadcast, absent means nothing.
// - Translation enabled and no translation found raises data access exception.
// - Write-through and inhibited attributes do not change the behaviour.
// - Translation and protection checked exactly as a store.
// - Changed and referenced bits are left unset.
module dbi_ctrl (
   input wire clk,
   input wire nrst,
   input wire req_valid,
   output wire req_ready,
   input wire base_is_r0,
   input wire [`DBI_ADDR_W-1:0] base_gpr,
   input wire [`DBI_ADDR_W-1:0] index_gpr,
   input wire [31:0] machine_state_reg,
   output wire mmu_req,
   output wire [`DBI_ADDR_W-1:0] mmu_ea,
   output wire mmu_is_store,
   output wire mmu_rc_update,
   input wire mmu_ack,
   input wire mmu_hit,
   input wire mmu_direct_store,
   input wire mmu_prot_fault,
   input wire [`DBI_ADDR_W-1:0] mmu_pa,
   input wire [2:0] storage_attr_bits,
   output wire cache_inv_req,
   output wire [`DBI_ADDR_W-1:0] cache_inv_addr,
   input wire cache_inv_ack,
   input wire cache_inv_hit,
   output wire snoop_inv_req,
   output wire [`DBI_ADDR_W-1:0] snoop_inv_addr,
   input wire snoop_inv_ack,
   output wire done_valid,
   output wire exc_program,
   output wire exc_data_access,
   output wire dsi_no_xlate,
   output wire dsi_prot,
   output wire [`DBI_ADDR_W-1:0] dsi_ea,
   output wire op_nop,
   output wire op_bcast,
   output wire op_local_hit,
   output wire busy
);

   // Engine states
   localparam [`DBI_ST_W-1:0] ST_IDLE = 3'h0;
   localparam [`DBI_ST_W-1:0] ST_XLATE = 3'h1;
   localparam [`DBI_ST_W-1:0] ST_LOCAL = 3'h2;
   localparam [`DBI_ST_W-1:0] ST_BCAST = 3'h3;
   localparam [`DBI_ST_W-1:0] ST_DONE = 3'h4;

   // Clear the offset bits so the whole block is addressed
   function [`DBI_ADDR_W-1:0] blk_align;
      input [`DBI_ADDR_W-1:0] addr;
      begin
         blk_align = {addr[`DBI_ADDR_W-1:`DBI_BLK_OFS_W], {`DBI_BLK_OFS_W{1'b0}}};
      end
   endfunction

   // State decode shared by the handshake outputs
   function st_is;
      input [`DBI_ST_W-1:0] st;
      input [`DBI_ST_W-1:0] code;
      begin
         st_is = (st == code);
      end
   endfunction

   wire [`DBI_ADDR_W-1:0] ea_sum;
   wire user_state;
   wire xlate_on;

   // Engine state
   reg [`DBI_ST_W-1:0] state_reg;
   reg [`DBI_ST_W-1:0] state_next;

   // Captured operands and mode
   reg [`DBI_ADDR_W-1:0] ea_reg;
   reg [`DBI_ADDR_W-1:0] ea_next;
   reg [`DBI_ADDR_W-1:0] blk_reg;
   reg [`DBI_ADDR_W-1:0] blk_next;
   reg xlate_on_reg;
   reg xlate_on_next;
   reg coherent_reg;
   reg coherent_next;

   // Exception flags
   reg exc_prog_reg;
   reg exc_prog_next;
   reg exc_dsi_reg;
   reg exc_dsi_next;
   reg no_xlate_reg;
   reg no_xlate_next;
   reg prot_reg;
   reg prot_next;

   // Outcome flags
   reg nop_reg;
   reg nop_next;
   reg bcast_reg;
   reg bcast_next;
   reg hit_reg;
   reg hit_next;

   // Address formation
   dbi_ea_gen u_ea_gen (
      .base_is_r0(base_is_r0),
      .base_gpr(base_gpr),
      .index_gpr(index_gpr),
      .ea(ea_sum)
   );

   // Privilege and translation mode from the machine state word
   assign user_state = machine_state_reg[`DBI_MSTATE_USER_BIT];
   assign xlate_on = machine_state_reg[`DBI_MSTATE_XLATE_BIT];

   // Handshake outputs follow the state
   assign req_ready = st_is(state_reg, ST_IDLE);
   assign busy = !st_is(state_reg, ST_IDLE);
   assign mmu_req = st_is(state_reg, ST_XLATE);
   assign cache_inv_req = st_is(state_reg, ST_LOCAL);
   assign snoop_inv_req = st_is(state_reg, ST_BCAST);
   assign done_valid = st_is(state_reg, ST_DONE);

   // Lookup is always a store-type access
   assign mmu_is_store = 1'b1;
   // Never ask the MMU to mark the page changed or referenced
   assign mmu_rc_update = 1'b0;

   // Data outputs from flops
   assign mmu_ea = ea_reg;
   assign cache_inv_addr = blk_reg;
   assign snoop_inv_addr = blk_reg;
   assign dsi_ea = ea_reg;
   assign exc_program = exc_prog_reg;
   assign exc_data_access = exc_dsi_reg;
   assign dsi_no_xlate = no_xlate_reg;
   assign dsi_prot = prot_reg;
   assign op_nop = nop_reg;
   assign op_bcast = bcast_reg;
   assign op_local_hit = hit_reg;

   // Next-state and result logic
   always @* begin
      state_next = state_reg;
      ea_next = ea_reg;
      blk_next = blk_reg;
      xlate_on_next = xlate_on_reg;
      coherent_next = coherent_reg;
      exc_prog_next = exc_prog_reg;
      exc_dsi_next = exc_dsi_reg;
      no_xlate_next = no_xlate_reg;
      prot_next = prot_reg;
      nop_next = nop_reg;
      bcast_next = bcast_reg;
      hit_next = hit_reg;
      case (state_reg)
         ST_IDLE: begin
            if (req_valid) begin
               // Fresh result for every accepted operation
               ea_next = ea_sum;
               xlate_on_next = xlate_on;
               coherent_next = 1'b0;
               exc_prog_next = 1'b0;
               exc_dsi_next = 1'b0;
               no_xlate_next = 1'b0;
               prot_next = 1'b0;
               nop_next = 1'b0;
               bcast_next = 1'b0;
               hit_next = 1'b0;
               if (user_state) begin
                  // Privileged: no cache is touched
                  exc_prog_next = 1'b1;
                  state_next = ST_DONE;
               end else begin
                  state_next = ST_XLATE;
               end
            end
         end
         ST_XLATE: begin
            if (mmu_ack) begin
               if (mmu_direct_store) begin
                  // Direct-store segment: finish without effect
                  nop_next = 1'b1;
                  state_next = ST_DONE;
               end else if (xlate_on_reg && !mmu_hit) begin
                  // Mapped access with no translation
                  exc_dsi_next = 1'b1;
                  no_xlate_next = 1'b1;
                  state_next = ST_DONE;
               end else if (mmu_prot_fault) begin
                  // Store permission fault
                  exc_dsi_next = 1'b1;
                  prot_next = 1'b1;
                  state_next = ST_DONE;
               end else begin
                  // Real mode uses the effective address as is
                  if (xlate_on_reg) begin
                     blk_next = blk_align(mmu_pa);
                  end else begin
                     blk_next = blk_align(ea_reg);
                  end
                  // Only the coherence bit steers the flow
                  coherent_next = storage_attr_bits[`DBI_ATTR_M_BIT];
                  state_next = ST_LOCAL;
               end
            end
         end
         ST_LOCAL: begin
            if (cache_inv_ack) begin
               // Cache drops the block without writeback
               hit_next = cache_inv_hit;
               if (coherent_reg) begin
                  // Broadcast even when the local copy was absent
                  state_next = ST_BCAST;
               end else begin
                  state_next = ST_DONE;
               end
            end
         end
         ST_BCAST: begin
            if (snoop_inv_ack) begin
               bcast_next = 1'b1;
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Engine state register
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Addresses of the current operation
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ea_reg <= {`DBI_ADDR_W{1'b0}};
         blk_reg <= {`DBI_ADDR_W{1'b0}};
      end else begin
         ea_reg <= ea_next;
         blk_reg <= blk_next;
      end
   end

   // Mode bits latched at acceptance and at lookup
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xlate_on_reg <= 1'b0;
         coherent_reg <= 1'b0;
      end else begin
         xlate_on_reg <= xlate_on_next;
         coherent_reg <= coherent_next;
      end
   end

   // Exception flags, held until the next request
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         exc_prog_reg <= 1'b0;
         exc_dsi_reg <= 1'b0;
         no_xlate_reg <= 1'b0;
         prot_reg <= 1'b0;
      end else begin
         exc_prog_reg <= exc_prog_next;
         exc_dsi_reg <= exc_dsi_next;
         no_xlate_reg <= no_xlate_next;
         prot_reg <= prot_next;
      end
   end

   // Outcome flags, held until the next request
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         nop_reg <= 1'b0;
         bcast_reg <= 1'b0;
         hit_reg <= 1'b0;
      end else begin
         nop_reg <= nop_next;
         bcast_reg <= bcast_next;
         hit_reg <= hit_next;
      end
   end

endmodule

/* tb/dbi_checker.sv */
module dbi_checker (
   input wire clk,
   input wire nrst,
   input wire req_valid,
   input wire req_ready,
   input wire [31:0] machine_state_reg,
   input wire busy,
   input wire mmu_req,
   input wire mmu_ack,
   input wire mmu_is_store,
   input wire mmu_rc_update,
   input wire mmu_hit,
   input wire mmu_direct_store,
   input wire [2:0] storage_attr_bits,
   input wire cache_inv_req,
   input wire cache_inv_ack,
   input wire [31:0] cache_inv_addr,
   input wire snoop_inv_req,
   input wire [31:0] snoop_inv_addr,
   input wire done_valid,
   input wire op_nop,
   input wire exc_program,
   input wire exc_data_access
);
   timeunit 1ns;
   timeprecision 1ps;
   reg m_reg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Coherence attribute captured at the lookup answer
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         m_reg <= 1'b0;
      else if (mmu_req && mmu_ack)
         m_reg <= storage_attr_bits[0];
   end
   sequence s_take;
      req_valid && req_ready;
   endsequence
   sequence s_mmu;
      mmu_req && mmu_ack;
   endsequence
   property p_user;
      s_take ##0 machine_state_reg[14] |=> done_valid && exc_program && !mmu_req;
   endproperty
   property p_store;
      busy |-> mmu_is_store && !mmu_rc_update;
   endproperty
   property p_align;
      cache_inv_req |-> cache_inv_addr[4:0] == 5'h00;
   endproperty
   property p_same;
      snoop_inv_req |-> snoop_inv_addr == cache_inv_addr;
   endproperty
   property p_nop;
      s_mmu ##0 mmu_direct_store |=> done_valid && op_nop && !cache_inv_req;
   endproperty
   property p_miss;
      s_mmu ##0 (!mmu_direct_store && machine_state_reg[4] && !mmu_hit)
         |=> done_valid && exc_data_access;
   endproperty
   property p_bcast;
      cache_inv_req && cache_inv_ack && m_reg |=> snoop_inv_req && !done_valid;
   endproperty
   property p_nobc;
      snoop_inv_req |-> m_reg;
   endproperty
   property p_ready;
      done_valid |=> req_ready && !busy;
   endproperty
   a_user: assert property (p_user) else $error("user attempt not refused");
   a_store: assert property (p_store) else $error("lookup not a plain store");
   a_align: assert property (p_align) else $error("invalidate not block aligned");
   a_same: assert property (p_same) else $error("snoop address differs");
   a_nop: assert property (p_nop) else $error("direct store not a no-op");
   a_miss: assert property (p_miss) else $error("missing translation ignored");
   a_bcast: assert property (p_bcast) else $error("coherent block not broadcast");
   a_nobc: assert property (p_nobc) else $error("broadcast without coherence");
   a_ready: assert property (p_ready) else $error("engine not idle after done");
endmodule

bind dbi_ctrl dbi_checker dbi_checker_i (.clk, .nrst, .req_valid, .req_ready,
   .machine_state_reg, .busy, .mmu_req, .mmu_ack, .mmu_is_store, .mmu_rc_update,
   .mmu_hit, .mmu_direct_store, .storage_attr_bits, .cache_inv_req, .cache_inv_ack,
   .cache_inv_addr, .snoop_inv_req, .snoop_inv_addr, .done_valid, .op_nop,
   .exc_program, .exc_data_access);

/* tb/dbi_far.sv */
module dbi_far (
   input wire clk,
   input wire nrst,
   input wire slow,
   input wire [6:0] cfg,
   input wire mmu_req,
   input wire [31:0] mmu_ea,
   input wire cache_inv_req,
   input wire snoop_inv_req,
   output wire mmu_ack,
   output wire mmu_hit,
   output wire mmu_direct_store,
   output wire mmu_prot_fault,
   output wire [31:0] mmu_pa,
   output wire [2:0] storage_attr_bits,
   output wire cache_inv_ack,
   output wire cache_inv_hit,
   output wire snoop_inv_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   reg tog_reg;
   wire go = !slow || tog_reg;
   // Slow mode answers only every other cycle
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         tog_reg <= 1'b0;
      else
         tog_reg <= !tog_reg;
   end
   // Answers are meaningful only with their acknowledge
   assign mmu_ack = mmu_req && go;
   assign {mmu_hit, mmu_direct_store, mmu_prot_fault, storage_attr_bits} =
      mmu_ack ? cfg[6:1] : ~cfg[6:1];
   assign mmu_pa = mmu_ack ? mmu_ea ^ 32'h0001_0000 : ~mmu_ea;
   assign cache_inv_ack = cache_inv_req && go;
   assign cache_inv_hit = cache_inv_ack ? cfg[0] : !cfg[0];
   assign snoop_inv_ack = snoop_inv_req && go;
endmodule

/* tb/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, req_valid, base_is_r0, slow;
   logic [31:0] base_gpr, index_gpr, machine_state_reg, r, rb, rx;
   logic [6:0] cfg;
   integer errors, n_tests, cyc, i;
   wire req_ready, mmu_req, mmu_is_store, mmu_rc_update, mmu_ack, mmu_hit;
   wire mmu_direct_store, mmu_prot_fault, cache_inv_req, cache_inv_ack, cache_inv_hit;
   wire snoop_inv_req, snoop_inv_ack, done_valid, exc_program, exc_data_access;
   wire dsi_no_xlate, dsi_prot, op_nop, op_bcast, op_local_hit, busy;
   wire [31:0] mmu_ea, mmu_pa, cache_inv_addr, snoop_inv_addr, dsi_ea;
   wire [2:0] storage_attr_bits;
   dbi_ctrl dbi_ctrl_i (.clk, .nrst, .req_valid, .req_ready, .base_is_r0, .base_gpr,
      .index_gpr, .machine_state_reg, .mmu_req, .mmu_ea, .mmu_is_store, .mmu_rc_update,
      .mmu_ack, .mmu_hit, .mmu_direct_store, .mmu_prot_fault, .mmu_pa, .storage_attr_bits,
      .cache_inv_req, .cache_inv_addr, .cache_inv_ack, .cache_inv_hit, .snoop_inv_req,
      .snoop_inv_addr, .snoop_inv_ack, .done_valid, .exc_program, .exc_data_access,
      .dsi_no_xlate, .dsi_prot, .dsi_ea, .op_nop, .op_bcast, .op_local_hit, .busy);
   dbi_far dbi_far_i (.clk, .nrst, .slow, .cfg, .mmu_req, .mmu_ea, .cache_inv_req,
      .snoop_inv_req, .mmu_ack, .mmu_hit, .mmu_direct_store, .mmu_prot_fault, .mmu_pa,
      .storage_attr_bits, .cache_inv_ack, .cache_inv_hit, .snoop_inv_ack);
   always #10 clk = ~clk;
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Expected flags: program, access, no-xlate, prot, nop, bcast, local hit
   function [6:0] exp_f(input [31:0] m, input [6:0] c);
      reg u, ds, ms, pf, go;
      begin
         u = m[14];
         ds = !u && c[5];
         ms = !u && !ds && m[4] && !c[6];
         pf = !u && !ds && !ms && c[4];
         go = !u && !ds && !ms && !c[4];
         exp_f = {u, ms || pf, ms, pf, ds, go && c[1], go && c[0]};
      end
   endfunction
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d errors %0d", n_tests, errors);
         if (errors == 0 && n_tests > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task run_op(input [31:0] m, input r0, input [31:0] b, x, input [6:0] c, input s);
      reg [6:0] f;
      reg [31:0] a, e, ma;
      reg lo, sn, go;
      begin
         f = exp_f(m, c);
         go = !(f[6] | f[5] | f[2]);
         e = (r0 ? 32'h0 : b) + x;
         lo = 0;
         sn = 0;
         a = 0;
         ma = 0;
         @(posedge clk);
         req_valid <= 1'b1;
         machine_state_reg <= m;
         base_is_r0 <= r0;
         base_gpr <= b;
         index_gpr <= x;
         cfg <= c;
         slow <= s;
         @(posedge clk);
         req_valid <= 1'b0;
         #1;
         while (!done_valid) begin
            if (mmu_req && mmu_ack)
               ma = mmu_ea;
            if (cache_inv_req && cache_inv_ack) begin
               lo = 1;
               a = cache_inv_addr;
            end
            if (snoop_inv_req && snoop_inv_ack)
               sn = 1;
            @(posedge clk);
            #1;
         end
         chk("flags", f, {exc_program, exc_data_access, dsi_no_xlate, dsi_prot,
            op_nop, op_bcast, op_local_hit});
         chk("ea", e, dsi_ea);
         chk("mmu_ea", f[6] ? 32'h0 : e, ma);
         chk("local", go, lo);
         chk("snoop", go && c[1], sn);
         if (go)
            chk("addr", (m[4] ? e ^ 32'h0001_0000 : e) & 32'hFFFF_FFE0, a);
         $display("op done ea %h", e);
      end
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         test_done;
      end
   end
   initial begin
      clk = 0;
      nrst = 0;
      {req_valid, base_is_r0, slow, base_gpr, index_gpr, machine_state_reg, cfg} = 0;
      {errors, n_tests, cyc} = 0;
      r = 32'h6585;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      run_op(32'h4010, 0, 32'h100, 32'h4, 7'h43, 0);
      run_op(32'h10, 0, 32'h200, 32'h8, 7'h63, 1);
      run_op(32'h10, 0, 32'h300, 32'hC, 7'h03, 0);
      run_op(32'h10, 0, 32'h400, 32'h3, 7'h53, 1);
      run_op(32'h10, 1, 32'hFFFF, 32'h7F3, 7'h42, 0);
      run_op(32'h0, 0, 32'h500, 32'h1, 7'h00, 1);
      for (i = 0; i < 8; i++)
         run_op(32'h0, 0, i * 32'h44, 32'h1F, {3'h4, i[2:0], 1'b1}, i[0]);
      repeat (40) begin
         r = lfsr(r);
         rb = lfsr(r);
         rx = lfsr(rb);
         run_op(r & 32'h4010, r[12], rb, rx, r[10:4], r[11]);
      end
      test_done;
   end
endmodule
